/* File: core/t4p_consts.vh */
`ifndef T4P_CONSTS_VH
`define T4P_CONSTS_VH

// register byte offsets; reads decode all 32 address bits, writes with upper bits set land on IRQ_EN
`define T4P_ADDR_W 5
`define T4P_ADDR_CTRL 5'h00
`define T4P_ADDR_STATUS 5'h04
`define T4P_ADDR_IRQ_STAT 5'h08
`define T4P_ADDR_IRQ_CLR 5'h0C
`define T4P_ADDR_IRQ_EN 5'h10

// control register fields
`define T4P_CTRL_LOOP 0

// status register fields
`define T4P_ST_RAW 0
`define T4P_ST_TEN_ABLE 1
`define T4P_ST_LOOP 2
`define T4P_ST_CARRIER 3
`define T4P_ST_RX_DV 4
`define T4P_ST_ALIGN_ERR 5

// interrupt event bits
`define T4P_IRQ_W 3
`define T4P_IRQ_RX_START 0
`define T4P_IRQ_ALIGN_ERR 1
`define T4P_IRQ_TX_START 2

// two-bit symbol codes
`define T4P_SYM_ZERO 2'h0
`define T4P_SYM_PLUS 2'h2
`define T4P_SYM_MINUS 2'h1
`define T4P_SYM_ILLEGAL 2'h3

// alignment limits, in symbol periods
`define T4P_CNT_W 3
`define T4P_MAX_SKEW 3'h3
`define T4P_HUNT_LIMIT 3'h7
`define T4P_DLY_W 2

// strap capture wait after reset release, in clocks
`define T4P_STRAP_WAIT 2'h3

// AXI responses
`define T4P_RESP_OKAY 2'h0
`define T4P_RESP_DECERR 2'h3

`endif

/* File: core/t4p_lane_align.v */
`timescale 1ns/1ps
`include "t4p_consts.vh"
module t4p_lane_align (
   input wire i_clock,
   input wire i_nrst,
   input wire i_step,
   input wire i_clear,
   input wire [1:0] i_sym,
   input wire [`T4P_CNT_W-1:0] i_count,
   input wire [`T4P_DLY_W-1:0] i_delay,
   output reg o_seen,
   output reg [`T4P_CNT_W-1:0] o_arrive,
   output reg [1:0] o_sym
);
   reg [1:0] tap1;
   reg [1:0] tap2;
   reg [1:0] tap3;

   // tap 0 is the symbol arriving at this step
   always @* begin
      case (i_delay)
         2'h0: o_sym = i_sym;
         2'h1: o_sym = tap1;
         2'h2: o_sym = tap2;
         default: o_sym = tap3;
      endcase
   end

   always @(posedge i_clock) begin
      if (!i_nrst) begin
         tap1 <= `T4P_SYM_ZERO;
         tap2 <= `T4P_SYM_ZERO;
         tap3 <= `T4P_SYM_ZERO;
         o_seen <= 1'b0;
         o_arrive <= {`T4P_CNT_W{1'b0}};
      end else if (i_clear) begin
         o_seen <= 1'b0;
         o_arrive <= {`T4P_CNT_W{1'b0}};
      end else if (i_step) begin
         tap1 <= i_sym;
         tap2 <= tap1;
         tap3 <= tap2;
         // first non-zero symbol marks stream start on this pair
         if (!o_seen && i_sym != `T4P_SYM_ZERO) begin
            o_seen <= 1'b1;
            o_arrive <= i_count;
         end
      end
   end
endmodule

/* File: core/t4p_port.v */
// Function
// - During loopback the line drivers are cut off from the medium and feed the receiver.
// - In loopback the transmit symbols come back in from the transmit symbol register, ahead of the line output register.
// - Loopback is on when the control loopback bit is one or the loopback pin is low.
// - A low mode strap selects the raw-symbol mode meant for repeaters.
// - In raw-symbol mode symbols go straight between the symbol pins and the line.
// - In raw-symbol mode the status register shows the 10 Mb/s ability as off.
// - The receiver aligns the three pairs and drives them on the six-bit output bus.
// - The transmitter takes the six-bit input bus on a rising edge of the symbol clock.
// - Pairs use bus bits one-zero, three-two and five-four.
// - Code 00 is zero, 10 is plus one, 01 is minus one, 11 sends zero and is received as zero except in the first data symbol after the marker.
// - Receive valid rises with the first data symbol after the start marker and stays up.
// - Receive valid is low whenever no carrier is seen.
// - Receive error goes high when the three pairs cannot be aligned.
// - In raw-symbol mode the receive enable input turns the receive bus, valid and error drivers on or off; otherwise they stay off.
// - With transmit enable high, symbols load on each rising edge of the input clock.
// - With transmit enable low the line sends ternary zero on every pair.
`timescale 1ns/1ps
`include "t4p_consts.vh"
module t4p_port (
   input wire i_clock,
   input wire i_nrst,
   input wire i_ext_input_clock,
   input wire i_tx_en,
   input wire [5:0] i_tx_sym,
   input wire i_loop_n,
   input wire i_mode,
   input wire i_rx_en,
   input wire [5:0] i_line_rx,
   input wire i_line_carrier,
   input wire i_pcs_tx_en,
   input wire [5:0] i_pcs_tx_sym,
   input wire [31:0] i_awaddr,
   input wire i_awvalid,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   input wire i_bready,
   input wire [31:0] i_araddr,
   input wire i_arvalid,
   input wire i_rready,
   output reg o_awready,
   output reg o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   output reg o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   output reg [5:0] o_rx_sym,
   output reg o_rx_dv,
   output reg o_rx_err,
   output reg o_rx_oe,
   output reg [5:0] o_pcs_rx_sym,
   output reg o_pcs_rx_dv,
   output reg o_pcs_rx_err,
   output reg [5:0] o_line_tx,
   output reg o_line_tx_drive,
   output reg o_raw_mode,
   output reg o_loop_active,
   output reg o_irq
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_HUNT = 4'b0010;
   localparam ST_DATA = 4'b0100;
   localparam ST_ERR = 4'b1000;

   wire [17:0] sync_out;
   wire clk_s;
   wire tx_en_s;
   wire [5:0] tx_sym_s;
   wire loop_n_s;
   wire mode_s;
   wire rx_en_s;
   wire [5:0] line_s;
   wire carrier_s;

   reg clk_prev;
   reg [1:0] strap_cnt;
   reg raw;
   reg ctrl_loop;
   reg loop;
   reg [5:0] tx_sym;
   reg tx_active;
   reg [3:0] state;
   reg [`T4P_CNT_W-1:0] sym_cnt;
   reg [`T4P_DLY_W*3-1:0] dly_reg;
   reg [5:0] rx_sym;
   reg rx_dv;
   reg rx_err;
   reg [`T4P_IRQ_W-1:0] irq_stat;
   reg [`T4P_IRQ_W-1:0] irq_en;
   reg aw_done;
   reg w_done;
   reg [`T4P_ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [31:0] rd_mux;
   reg rd_hit;

   t4p_sync #(
      .W(18)
   ) u_sync (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_async({i_ext_input_clock, i_tx_en, i_tx_sym, i_loop_n, i_mode, i_rx_en,
         i_line_rx, i_line_carrier}),
      .o_sync(sync_out)
   );
   assign {clk_s, tx_en_s, tx_sym_s, loop_n_s, mode_s, rx_en_s, line_s, carrier_s} = sync_out;

   wire step = clk_s & ~clk_prev;

   function [5:0] clean_sym;
      input [5:0] s;
      integer k;
      begin
         clean_sym = s;
         for (k = 0; k < 3; k = k + 1) begin
            if (s[2*k +: 2] == `T4P_SYM_ILLEGAL) begin
               clean_sym[2*k +: 2] = `T4P_SYM_ZERO;
            end
         end
      end
   endfunction

   wire next_loop = ctrl_loop | ~loop_n_s;

   // receive input taken from the transmit path in loopback, else from the line
   wire [5:0] rx_in = loop ? tx_sym : line_s;
   wire carrier_in = loop ? tx_active : carrier_s;

   wire [2:0] seen;
   wire [`T4P_CNT_W*3-1:0] arrive;
   wire [5:0] aligned;
   reg [`T4P_DLY_W*3-1:0] dly_calc;
   reg [`T4P_CNT_W-1:0] a_max;
   reg [`T4P_CNT_W-1:0] a_min;
   wire [`T4P_DLY_W*3-1:0] dly_sel = (state == ST_DATA) ? dly_reg : dly_calc;
   wire all_seen = &seen;
   wire skew_bad = (a_max - a_min) > `T4P_MAX_SKEW;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : lane
         t4p_lane_align u_lane (
            .i_clock(i_clock),
            .i_nrst(i_nrst),
            .i_step(step),
            .i_clear(state == ST_IDLE),
            .i_sym(rx_in[2*g +: 2]),
            .i_count(sym_cnt),
            .i_delay(dly_sel[`T4P_DLY_W*g +: `T4P_DLY_W]),
            .o_seen(seen[g]),
            .o_arrive(arrive[`T4P_CNT_W*g +: `T4P_CNT_W]),
            .o_sym(aligned[2*g +: 2])
         );
      end
   endgenerate

   // latest lane waits for none, earlier lanes wait the difference
   always @* begin : calc
      integer k;
      reg [`T4P_CNT_W-1:0] d;
      d = {`T4P_CNT_W{1'b0}};
      a_max = arrive[0 +: `T4P_CNT_W];
      a_min = arrive[0 +: `T4P_CNT_W];
      for (k = 1; k < 3; k = k + 1) begin
         if (arrive[`T4P_CNT_W*k +: `T4P_CNT_W] > a_max) begin
            a_max = arrive[`T4P_CNT_W*k +: `T4P_CNT_W];
         end
         if (arrive[`T4P_CNT_W*k +: `T4P_CNT_W] < a_min) begin
            a_min = arrive[`T4P_CNT_W*k +: `T4P_CNT_W];
         end
      end
      for (k = 0; k < 3; k = k + 1) begin
         d = a_max - arrive[`T4P_CNT_W*k +: `T4P_CNT_W];
         dly_calc[`T4P_DLY_W*k +: `T4P_DLY_W] = d[`T4P_DLY_W-1:0];
      end
   end

   // strap caught a few clocks after reset release, once the synchroniser holds it
   always @(posedge i_clock) begin
      if (!i_nrst) begin
         strap_cnt <= 2'h0;
         raw <= 1'b0;
      end else if (strap_cnt != `T4P_STRAP_WAIT) begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == `T4P_STRAP_WAIT - 2'h1) begin
            raw <= ~mode_s;
         end
      end
   end

   // transmit path
   always @(posedge i_clock) begin
      if (!i_nrst) begin
         clk_prev <= 1'b0;
         loop <= 1'b0;
         tx_sym <= {3{`T4P_SYM_ZERO}};
         tx_active <= 1'b0;
         o_line_tx <= {3{`T4P_SYM_ZERO}};
         o_line_tx_drive <= 1'b0;
      end else begin
         clk_prev <= clk_s;
         loop <= next_loop;
         if (step) begin
            if (raw) begin
               // pins go straight to the line
               tx_sym <= tx_en_s ? clean_sym(tx_sym_s) : {3{`T4P_SYM_ZERO}};
               tx_active <= tx_en_s;
            end else begin
               tx_sym <= i_pcs_tx_en ? clean_sym(i_pcs_tx_sym) : {3{`T4P_SYM_ZERO}};
               tx_active <= i_pcs_tx_en;
            end
         end
         // isolated from the medium in loopback
         o_line_tx <= (loop || !tx_active) ? {3{`T4P_SYM_ZERO}} : tx_sym;
         o_line_tx_drive <= ~loop;
      end
   end

   // receive alignment and framing
   always @(posedge i_clock) begin
      if (!i_nrst) begin
         state <= ST_IDLE;
         sym_cnt <= {`T4P_CNT_W{1'b0}};
         dly_reg <= {3*`T4P_DLY_W{1'b0}};
         rx_sym <= {3{`T4P_SYM_ZERO}};
         rx_dv <= 1'b0;
         rx_err <= 1'b0;
      end else begin
         if (!carrier_in) begin
            rx_dv <= 1'b0;
         end
         if (step) begin
            case (state)
               ST_IDLE: begin
                  rx_err <= 1'b0;
                  rx_sym <= {3{`T4P_SYM_ZERO}};
                  sym_cnt <= {`T4P_CNT_W{1'b0}};
                  if (carrier_in) begin
                     state <= ST_HUNT;
                  end
               end
               ST_HUNT: begin
                  sym_cnt <= sym_cnt + {{`T4P_CNT_W-1{1'b0}}, 1'b1};
                  if (!carrier_in) begin
                     state <= ST_IDLE;
                  end else if (all_seen && skew_bad) begin
                     state <= ST_ERR;
                     rx_err <= 1'b1;
                  end else if (all_seen) begin
                     // valid with first data symbol after marker
                     state <= ST_DATA;
                     dly_reg <= dly_calc;
                     rx_sym <= aligned;
                     rx_dv <= 1'b1;
                  end else if (sym_cnt == `T4P_HUNT_LIMIT) begin
                     state <= ST_ERR;
                     rx_err <= 1'b1;
                  end
               end
               ST_DATA: begin
                  if (!carrier_in) begin
                     state <= ST_IDLE;
                     rx_sym <= {3{`T4P_SYM_ZERO}};
                  end else begin
                     rx_sym <= clean_sym(aligned);
                     rx_dv <= 1'b1;
                  end
               end
               ST_ERR: begin
                  if (!carrier_in) begin
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // pin outputs and status; raw mode uses the pins, else the coding sublayer side
   always @(posedge i_clock) begin
      if (!i_nrst) begin
         o_rx_sym <= {3{`T4P_SYM_ZERO}};
         o_rx_dv <= 1'b0;
         o_rx_err <= 1'b0;
         o_rx_oe <= 1'b0;
         o_pcs_rx_sym <= {3{`T4P_SYM_ZERO}};
         o_pcs_rx_dv <= 1'b0;
         o_pcs_rx_err <= 1'b0;
         o_raw_mode <= 1'b0;
         o_loop_active <= 1'b0;
      end else begin
         // received symbols to the pins in raw mode
         o_rx_sym <= raw ? rx_sym : {3{`T4P_SYM_ZERO}};
         o_rx_dv <= raw & rx_dv & carrier_in;
         o_rx_err <= raw & rx_err;
         // receive enable drives the output enable
         o_rx_oe <= raw & rx_en_s;
         o_pcs_rx_sym <= raw ? {3{`T4P_SYM_ZERO}} : rx_sym;
         o_pcs_rx_dv <= ~raw & rx_dv & carrier_in;
         o_pcs_rx_err <= ~raw & rx_err;
         o_raw_mode <= raw;
         o_loop_active <= loop;
      end
   end

   // sticky events; a set in the clearing cycle wins
   reg rx_dv_prev;
   reg rx_err_prev;
   reg tx_act_prev;
   wire [`T4P_IRQ_W-1:0] events = {tx_active & ~tx_act_prev, rx_err & ~rx_err_prev,
      rx_dv & ~rx_dv_prev};
   wire wr_fire = aw_done & w_done & ~o_bvalid;
   wire clr_hit = wr_fire && aw_addr == `T4P_ADDR_IRQ_CLR && w_strb[0];
   wire [`T4P_IRQ_W-1:0] clr_bits = clr_hit ? w_data[`T4P_IRQ_W-1:0] : {`T4P_IRQ_W{1'b0}};

   always @(posedge i_clock) begin
      if (!i_nrst) begin
         rx_dv_prev <= 1'b0;
         rx_err_prev <= 1'b0;
         tx_act_prev <= 1'b0;
         irq_stat <= {`T4P_IRQ_W{1'b0}};
         o_irq <= 1'b0;
      end else begin
         rx_dv_prev <= rx_dv;
         rx_err_prev <= rx_err;
         tx_act_prev <= tx_active;
         irq_stat <= (irq_stat & ~clr_bits) | events;
         o_irq <= |(irq_stat & irq_en);
      end
   end

   // register read view
   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (i_araddr[`T4P_ADDR_W-1:0])
         `T4P_ADDR_CTRL: rd_mux[`T4P_CTRL_LOOP] = ctrl_loop;
         `T4P_ADDR_STATUS: begin
            rd_mux[`T4P_ST_RAW] = raw;
            // no 10 Mb/s ability in raw mode
            rd_mux[`T4P_ST_TEN_ABLE] = ~raw;
            rd_mux[`T4P_ST_LOOP] = loop;
            rd_mux[`T4P_ST_CARRIER] = carrier_in;
            rd_mux[`T4P_ST_RX_DV] = rx_dv;
            rd_mux[`T4P_ST_ALIGN_ERR] = rx_err;
         end
         `T4P_ADDR_IRQ_STAT: rd_mux[`T4P_IRQ_W-1:0] = irq_stat;
         `T4P_ADDR_IRQ_CLR: rd_mux = 32'h00000000;
         `T4P_ADDR_IRQ_EN: rd_mux[`T4P_IRQ_W-1:0] = irq_en;
         default: rd_hit = 1'b0;
      endcase
      if (i_araddr[31:`T4P_ADDR_W] != {(32-`T4P_ADDR_W){1'b0}}) begin
         rd_hit = 1'b0;
      end
   end

   // AXI4-Lite slave
   always @(posedge i_clock) begin
      if (!i_nrst) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= `T4P_RESP_OKAY;
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rresp <= `T4P_RESP_OKAY;
         o_rdata <= 32'h00000000;
         aw_done <= 1'b0;
         w_done <= 1'b0;
         aw_addr <= {`T4P_ADDR_W{1'b0}};
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         ctrl_loop <= 1'b0;
         irq_en <= {`T4P_IRQ_W{1'b0}};
      end else begin
         if (i_awvalid && o_awready) begin
            o_awready <= 1'b0;
            aw_done <= 1'b1;
            aw_addr <= (i_awaddr[31:`T4P_ADDR_W] == {(32-`T4P_ADDR_W){1'b0}}) ?
               i_awaddr[`T4P_ADDR_W-1:0] : `T4P_ADDR_IRQ_CLR + 5'h04;
         end
         if (i_wvalid && o_wready) begin
            o_wready <= 1'b0;
            w_done <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (wr_fire) begin
            aw_done <= 1'b0;
            w_done <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= `T4P_RESP_OKAY;
            case (aw_addr)
               `T4P_ADDR_CTRL: begin
                  if (w_strb[0]) begin
                     ctrl_loop <= w_data[`T4P_CTRL_LOOP];
                  end
               end
               `T4P_ADDR_IRQ_EN: begin
                  if (w_strb[0]) begin
                     irq_en <= w_data[`T4P_IRQ_W-1:0];
                  end
               end
               `T4P_ADDR_STATUS, `T4P_ADDR_IRQ_STAT, `T4P_ADDR_IRQ_CLR: begin
                  o_bresp <= `T4P_RESP_OKAY;
               end
               default: o_bresp <= `T4P_RESP_DECERR;
            endcase
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
         if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_mux;
            o_rresp <= rd_hit ? `T4P_RESP_OKAY : `T4P_RESP_DECERR;
         end
         if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end
endmodule

/* File: core/t4p_sync.v */
`timescale 1ns/1ps
module t4p_sync #(
   parameter W = 1
) (
   input wire i_clock,
   input wire i_nrst,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);
   reg [W-1:0] stage1;

   // stage1 is read by o_sync only
   always @(posedge i_clock) begin
      if (!i_nrst) begin
         stage1 <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule

/* File: verification/t4p_port_checker.sv */
`timescale 1ns/1ps
module t4p_port_checker (
   input logic i_clock,
   input logic i_nrst,
   input logic i_rx_en,
   input logic i_loop_n,
   input logic i_line_carrier,
   input logic i_awvalid,
   input logic i_wvalid,
   input logic i_bready,
   input logic i_arvalid,
   input logic o_awready,
   input logic o_wready,
   input logic [1:0] o_bresp,
   input logic o_bvalid,
   input logic o_arready,
   input logic o_rvalid,
   input logic [5:0] o_rx_sym,
   input logic o_rx_dv,
   input logic o_rx_oe,
   input logic [5:0] o_pcs_rx_sym,
   input logic o_pcs_rx_dv,
   input logic [5:0] o_line_tx,
   input logic o_line_tx_drive,
   input logic o_raw_mode,
   input logic o_loop_active
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);
   sequence s_both_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_no_carrier;
      (!i_line_carrier && !o_loop_active) [*5];
   endsequence
   a_write_answer: assert property (s_both_taken |-> ##2 o_bvalid)
      else $error("write response not on time");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data not on time");
   a_resp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");
   a_oe_off: assert property (!i_rx_en [*4] |-> !o_rx_oe)
      else $error("receive drivers still enabled");
   a_loop_pin: assert property (!i_loop_n [*5] |-> o_loop_active)
      else $error("loop pin ignored");
   a_loop_isolates: assert property (o_loop_active |-> !o_line_tx_drive && o_line_tx == 6'h00)
      else $error("line driven during loopback");
   a_no_code_three: assert property (!(&o_rx_sym[1:0]) && !(&o_rx_sym[3:2])
      && !(&o_rx_sym[5:4]) && !(&o_line_tx[1:0]) && !(&o_line_tx[3:2]) && !(&o_line_tx[5:4]))
      else $error("code 11 seen on a symbol bus");
   a_dv_carrier: assert property (s_no_carrier |-> !o_rx_dv)
      else $error("receive valid without carrier");
   a_raw_pcs_quiet: assert property (o_raw_mode |-> !o_pcs_rx_dv && o_pcs_rx_sym == 6'h00)
      else $error("coding path active in raw mode");
endmodule
bind t4p_port t4p_port_checker u_chk (.i_clock, .i_nrst, .i_rx_en, .i_loop_n, .i_line_carrier,
   .i_awvalid, .i_wvalid, .i_bready, .i_arvalid, .o_awready, .o_wready, .o_bresp, .o_bvalid,
   .o_arready, .o_rvalid, .o_rx_sym, .o_rx_dv, .o_rx_oe, .o_pcs_rx_sym, .o_pcs_rx_dv,
   .o_line_tx, .o_line_tx_drive, .o_raw_mode, .o_loop_active);

/* File: verification/t4p_rep_model.sv */
`timescale 1ns/1ps
module t4p_rep_model (
   input wire i_clock,
   output reg o_ext_input_clock,
   output reg o_tx_en,
   output reg [5:0] o_tx_sym
);
   initial begin
      o_ext_input_clock = 1'b0;
      o_tx_en = 1'b0;
      o_tx_sym = 6'h3F;
   end
   // one symbol per 180 ns; clock parked low between frames
   task send(input en, input [5:0] s);
      begin
         @(posedge i_clock);
         o_tx_en <= en;
         // idle bus shows inverse of last word, not stale data
         o_tx_sym <= en ? s : ~o_tx_sym;
         repeat (4) @(posedge i_clock);
         o_ext_input_clock <= 1'b1;
         repeat (4) @(posedge i_clock);
         o_ext_input_clock <= 1'b0;
      end
   endtask
endmodule

/* File: verification/tb_t4_pma_port_and_loopback.sv */
`timescale 1ns/1ps
`include "t4p_consts.vh"
module tb_t4_pma_port_and_loopback;
   localparam [5:0] DATA = 6'h19;
   reg i_clock = 1'b0;
   reg i_nrst = 1'b0;
   reg i_rx_en = 1'b1;
   reg i_loop_n = 1'b1;
   reg i_line_carrier = 1'b0;
   reg [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, rd;
   reg i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   reg [1:0] rr;
   reg [12:0] rows [0:6];
   integer fail_count = 0, n_tests = 0, i;
   wire i_ext_input_clock, i_tx_en, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   wire o_rx_dv, o_rx_err, o_rx_oe, o_pcs_rx_dv, o_line_tx_drive, o_raw_mode, o_loop_active, o_irq;
   wire [1:0] o_bresp, o_rresp;
   wire [31:0] o_rdata;
   wire [5:0] i_tx_sym, o_rx_sym, o_line_tx;
   // pin view of the receive side, floating when disabled
   wire [7:0] rx_pins = o_rx_oe ? {o_rx_err, o_rx_dv, o_rx_sym} : 8'hZZ;
   t4p_rep_model rep (.i_clock, .o_ext_input_clock(i_ext_input_clock), .o_tx_en(i_tx_en),
      .o_tx_sym(i_tx_sym));
   t4p_port dut (.i_clock, .i_nrst, .i_ext_input_clock, .i_tx_en, .i_tx_sym, .i_loop_n,
      .i_mode(1'b0), .i_rx_en, .i_line_rx(6'h00), .i_line_carrier, .i_pcs_tx_en(1'b0),
      .i_pcs_tx_sym(6'h00), .i_awaddr, .i_awvalid, .i_wdata, .i_wstrb(4'hF), .i_wvalid,
      .i_bready, .i_araddr, .i_arvalid, .i_rready, .o_awready, .o_wready, .o_bresp, .o_bvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .o_rx_sym, .o_rx_dv, .o_rx_err, .o_rx_oe,
      .o_pcs_rx_sym(), .o_pcs_rx_dv, .o_pcs_rx_err(), .o_line_tx, .o_line_tx_drive,
      .o_raw_mode, .o_loop_active, .o_irq);
   initial begin
      forever #10 i_clock = ~i_clock;
   end
   task stop_test;
      begin
         $display("checks %0d errors %0d", n_tests, fail_count);
         if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
         end else begin
            $display("Test failed");
         end
         $finish;
      end
   endtask
   task chk(input ok);
      begin
         n_tests = n_tests + 1;
         if (!ok) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t check %0d mismatch", $time, n_tests);
         end
      end
   endtask
   task timeout;
      begin
         fail_count = fail_count + 1;
         $display("[ERR] %0t bus wait ran out", $time);
         stop_test;
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge i_clock);
   endtask
   task axw(input [31:0] a, input [31:0] d, input [1:0] er);
      integer k;
      reg done;
      begin
         done = 1'b0;
         @(posedge i_clock);
         i_awaddr <= a;
         i_wdata <= d;
         i_awvalid <= 1'b1;
         i_wvalid <= 1'b1;
         i_bready <= 1'b1;
         for (k = 0; k < 40 && !done; k = k + 1) begin
            @(posedge i_clock);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) begin
               done = 1'b1;
               i_bready <= 1'b0;
               chk(o_bresp === er);
            end
         end
         if (!done) timeout;
      end
   endtask
   task axr(input [31:0] a);
      integer k;
      reg done;
      begin
         done = 1'b0;
         @(posedge i_clock);
         i_araddr <= a;
         i_arvalid <= 1'b1;
         i_rready <= 1'b1;
         for (k = 0; k < 40 && !done; k = k + 1) begin
            @(posedge i_clock);
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) begin
               done = 1'b1;
               i_rready <= 1'b0;
               rd = o_rdata;
               rr = o_rresp;
            end
         end
         if (!done) timeout;
      end
   endtask
   initial begin
      // {enable, symbols in, line symbols out}
      rows[0] = 13'h1AAA;
      rows[1] = 13'h1555;
      rows[2] = 13'h1FC0;
      rows[3] = 13'h1E49;
      rows[4] = 13'h1000;
      rows[5] = 13'h1186;
      rows[6] = 13'h0A80;
      tick(3);
      i_nrst <= 1'b1;
      chk(o_irq === 1'b0 && o_line_tx === 6'h00 && o_raw_mode === 1'b0);
      tick(8);
      chk(o_raw_mode === 1'b1);
      axr(`T4P_ADDR_STATUS);
      chk(rr === `T4P_RESP_OKAY && (rd & 32'h3) === 32'h1);
      axr(32'h14);
      chk(rr === `T4P_RESP_DECERR && rd === 32'h0);
      axw(32'h18, 32'h1, `T4P_RESP_DECERR);
      for (i = 0; i < 7; i = i + 1) begin
         rep.send(rows[i][12], rows[i][11:6]);
         tick(2);
         chk(o_line_tx === rows[i][5:0]);
      end
      chk(o_line_tx_drive === 1'b1 && o_rx_oe === 1'b1);
      // good frame through pin loopback, rx start interrupt enabled
      axw(`T4P_ADDR_IRQ_CLR, 32'h7, `T4P_RESP_OKAY);
      axw(`T4P_ADDR_IRQ_EN, 32'h1, `T4P_RESP_OKAY);
      i_loop_n <= 1'b0;
      tick(6);
      chk(o_loop_active === 1'b1 && o_line_tx_drive === 1'b0);
      rep.send(1'b1, 6'h00);
      rep.send(1'b1, 6'h2A);
      tick(2);
      chk(o_rx_dv === 1'b0);
      for (i = 0; i < 4; i = i + 1) rep.send(1'b1, DATA);
      tick(2);
      chk(o_rx_dv === 1'b1 && o_rx_sym === DATA && rx_pins === {2'b01, DATA});
      chk(o_line_tx === 6'h00 && o_pcs_rx_dv === 1'b0 && o_irq === 1'b1);
      rep.send(1'b0, 6'h00);
      tick(6);
      chk(o_rx_dv === 1'b0);
      axw(`T4P_ADDR_IRQ_EN, 32'h0, `T4P_RESP_OKAY);
      tick(2);
      chk(o_irq === 1'b0);
      axr(`T4P_ADDR_IRQ_STAT);
      chk(rd[0] === 1'b1);
      axw(`T4P_ADDR_IRQ_CLR, 32'h1, `T4P_RESP_OKAY);
      axr(`T4P_ADDR_IRQ_STAT);
      chk(rd[0] === 1'b0);
      // register loopback, pairs skewed by five symbols
      i_loop_n <= 1'b1;
      axw(`T4P_ADDR_CTRL, 32'h1, `T4P_RESP_OKAY);
      axr(`T4P_ADDR_CTRL);
      chk(rd === 32'h1 && o_loop_active === 1'b1);
      rep.send(1'b1, 6'h00);
      rep.send(1'b1, 6'h02);
      for (i = 0; i < 7; i = i + 1) rep.send(1'b1, i < 4 ? 6'h00 : 6'h28);
      tick(2);
      chk(o_rx_err === 1'b1 && o_rx_dv === 1'b0);
      axr(`T4P_ADDR_IRQ_STAT);
      chk(rd[1] === 1'b1);
      rep.send(1'b0, 6'h00);
      i_rx_en <= 1'b0;
      tick(6);
      chk(o_rx_oe === 1'b0 && rx_pins === 8'hZZ);
      // loopback off again: carrier now comes from the line pin
      axw(`T4P_ADDR_CTRL, 32'h0, `T4P_RESP_OKAY);
      i_line_carrier <= 1'b1;
      tick(6);
      axr(`T4P_ADDR_STATUS);
      chk(rd[`T4P_ST_CARRIER] === 1'b1 && o_rx_dv === 1'b0);
      chk(o_loop_active === 1'b0 && o_line_tx_drive === 1'b1);
      stop_test;
   end
endmodule
